/* File: ptt_counter.sv */
// Down-counter core of the periodic tick timer
`timescale 1ns/1ps
module ptt_counter #(
   parameter int unsigned WIDTH = 24
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic clear,
   input wire logic [WIDTH-1:0] reload,
   output logic [WIDTH-1:0] count_q,
   output logic zero_evt_q
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic zero_evt;
   } ptt_cnt_state_t;

   ptt_cnt_state_t st_q;
   ptt_cnt_state_t st_d;

   always_comb
   begin
      st_d = st_q;
      st_d.zero_evt = 1'b0;
      if (clear)
      begin
         st_d.count = '0;
      end
      else if (run)
      begin
         if (st_q.count == '0)
         begin
            st_d.count = reload;
         end
         else
         begin
            st_d.count = st_q.count - 1'b1;
            // Event marks the step onto zero, not a halted zero
            st_d.zero_evt = (st_q.count == {{(WIDTH-1){1'b0}}, 1'b1});
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign count_q = st_q.count;
   assign zero_evt_q = st_q.zero_evt;

   zero_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (run && !clear && st_q.count == 1) |=> (st_q.count == 0 && st_q.zero_evt))
      else $error("Count did not reach zero with event");
   reload_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (run && !clear && st_q.count == 0) |=> (st_q.count == $past(reload)))
      else $error("Reload not taken at zero");
   halt_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!run && !clear) |=> $stable(st_q.count))
      else $error("Counter moved while halted");
   clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clear |=> (st_q.count == 0 && !st_q.zero_evt))
      else $error("Clear did not zero counter");
endmodule : ptt_counter

/* File: ptt_pkg.sv */
// Package for the periodic tick timer: offsets, fields, reset values, types
package ptt_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned CNT_W = 24;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_RELOAD = 8'h14;
   localparam logic [7:0] OFS_CURR = 8'h18;
   localparam logic [7:0] OFS_CALIB = 8'h1C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
   localparam int unsigned BIT_RUN = 0;
   localparam int unsigned BIT_IRQ_EN = 1;
   localparam int unsigned BIT_RSVD_ONE = 2;
   localparam int unsigned BIT_ZERO_FLAG = 16;
   localparam int unsigned BIT_INEXACT = 30;
   localparam int unsigned BIT_NO_REF = 31;
   localparam logic [23:0] RST_RELOAD = 24'h000000;
   localparam logic [23:0] RST_CURR = 24'h000000;
   localparam logic [23:0] RST_DEFAULT_PERIOD = 24'h000004;
   localparam logic [31:0] RST_CTRL_VALUE = 32'h00000004;
   localparam logic [31:0] RST_CALIB_VALUE = 32'h00000004;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ptt_req_t;

   typedef struct packed {
      logic run;
      logic irq_enable;
      logic zero_reached_flag;
      logic calib_inexact_flag;
      logic no_ref_clock_flag;
      logic [CNT_W-1:0] reload;
      logic [CNT_W-1:0] default_period_value;
      logic tick_stat;
      logic tick_mask;
   } ptt_regs_t;
endpackage : ptt_pkg

/* File: ptt_top.sv */
// Periodic tick timer: register slave, flags and interrupt around the down-counter
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module ptt_top #(
   parameter int unsigned CNT_W = ptt_pkg::CNT_W
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [ptt_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic irq_ack,
   output logic [31:0] reg_rdata,
   output logic tick_irq
);
   typedef struct packed {
      ptt_pkg::ptt_regs_t regs;
      logic [31:0] rdata;
      logic irq_pend;
      logic irq_out;
   } ptt_state_t;

   ptt_state_t st_q;
   ptt_state_t st_d;
   ptt_pkg::ptt_req_t req;
   logic [CNT_W-1:0] count;
   logic zero_evt;
   logic cur_clear;
   logic ctrl_rd;

   // One driver for the whole request word; per-field assigns would give the variable several drivers
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign cur_clear = req.wr && (req.addr == ptt_pkg::OFS_CURR);
   assign ctrl_rd = req.rd && (req.addr == ptt_pkg::OFS_CTRL);

   ptt_counter #(
      .WIDTH(CNT_W)
   ) u_counter (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .run(st_q.regs.run),
      .clear(cur_clear),
      .reload(st_q.regs.reload),
      .count_q(count),
      .zero_evt_q(zero_evt)
   );

   always_comb
   begin
      st_d = st_q;
      st_d.rdata = 32'h00000000;
      // Read mux; reserved bits read as zero apart from the fixed one at bit 2
      if (req.rd)
      begin
         case (req.addr)
            ptt_pkg::OFS_CTRL:
            begin
               st_d.rdata[ptt_pkg::BIT_RUN] = st_q.regs.run;
               st_d.rdata[ptt_pkg::BIT_IRQ_EN] = st_q.regs.irq_enable;
               st_d.rdata[ptt_pkg::BIT_RSVD_ONE] = 1'b1;
               st_d.rdata[ptt_pkg::BIT_ZERO_FLAG] = st_q.regs.zero_reached_flag;
            end
            ptt_pkg::OFS_RELOAD: st_d.rdata[CNT_W-1:0] = st_q.regs.reload;
            ptt_pkg::OFS_CURR: st_d.rdata[CNT_W-1:0] = count;
            ptt_pkg::OFS_CALIB:
            begin
               st_d.rdata[CNT_W-1:0] = st_q.regs.default_period_value;
               st_d.rdata[ptt_pkg::BIT_INEXACT] = st_q.regs.calib_inexact_flag;
               st_d.rdata[ptt_pkg::BIT_NO_REF] = st_q.regs.no_ref_clock_flag;
            end
            ptt_pkg::OFS_IRQ_STAT: st_d.rdata[0] = st_q.regs.tick_stat;
            ptt_pkg::OFS_IRQ_MASK: st_d.rdata[0] = st_q.regs.tick_mask;
            default: st_d.rdata = 32'h00000000;
         endcase
      end
      if (req.wr)
      begin
         case (req.addr)
            ptt_pkg::OFS_CTRL:
            begin
               st_d.regs.run = req.wdata[ptt_pkg::BIT_RUN];
               st_d.regs.irq_enable = req.wdata[ptt_pkg::BIT_IRQ_EN];
            end
            ptt_pkg::OFS_RELOAD: st_d.regs.reload = req.wdata[CNT_W-1:0];
            ptt_pkg::OFS_CALIB:
            begin
               st_d.regs.default_period_value = req.wdata[CNT_W-1:0];
               st_d.regs.calib_inexact_flag = req.wdata[ptt_pkg::BIT_INEXACT];
               st_d.regs.no_ref_clock_flag = req.wdata[ptt_pkg::BIT_NO_REF];
            end
            ptt_pkg::OFS_IRQ_STAT:
            begin
               if (req.wdata[0])
               begin
                  st_d.regs.tick_stat = 1'b0;
               end
            end
            ptt_pkg::OFS_IRQ_MASK: st_d.regs.tick_mask = req.wdata[0];
            default: st_d.regs = st_d.regs;
         endcase
      end
      // Clears first, so an event in the same cycle still wins
      if (ctrl_rd || cur_clear)
      begin
         st_d.regs.zero_reached_flag = 1'b0;
      end
      if (irq_ack)
      begin
         st_d.irq_pend = 1'b0;
      end
      if (zero_evt)
      begin
         st_d.regs.zero_reached_flag = 1'b1;
         st_d.regs.tick_stat = 1'b1;
         // Request only with both enables; held until the core accepts it
         if (st_q.regs.run && st_q.regs.irq_enable)
         begin
            st_d.irq_pend = 1'b1;
         end
      end
      // Gate by the interrupt enable so clearing it withdraws a pending request
      st_d.irq_out = (st_d.irq_pend && st_d.regs.irq_enable && st_d.regs.run)
         || (st_d.regs.tick_stat && st_d.regs.tick_mask);
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_q.regs.run <= 1'b0;
         st_q.regs.irq_enable <= 1'b0;
         st_q.regs.zero_reached_flag <= 1'b0;
         st_q.regs.calib_inexact_flag <= 1'b0;
         st_q.regs.no_ref_clock_flag <= 1'b0;
         st_q.regs.reload <= ptt_pkg::RST_RELOAD;
         st_q.regs.default_period_value <= ptt_pkg::RST_DEFAULT_PERIOD;
         st_q.regs.tick_stat <= 1'b0;
         st_q.regs.tick_mask <= 1'b0;
         st_q.rdata <= 32'h00000000;
         st_q.irq_pend <= 1'b0;
         st_q.irq_out <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign tick_irq = st_q.irq_out;

   flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      zero_evt |=> st_q.regs.zero_reached_flag)
      else $error("Zero flag not set on zero event");
   flag_rd_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (ctrl_rd && !zero_evt) |=> !st_q.regs.zero_reached_flag)
      else $error("Control read did not clear flag");
   flag_rd_val_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ctrl_rd |=> (reg_rdata[16] == $past(st_q.regs.zero_reached_flag) && reg_rdata[2]))
      else $error("Control read data wrong");
   cur_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == 8'h18) |=> (reg_rdata[23:0] == $past(count)))
      else $error("Current read not live count");
   cur_clr_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (cur_clear && !zero_evt) |=> (!st_q.regs.zero_reached_flag && count == 0))
      else $error("Current write did not clear");
   calib_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == 8'h1C) |=> (st_q.regs.default_period_value == $past(reg_wdata[23:0])))
      else $error("Calibration write lost");
   // A control write in the event cycle may withdraw the request, so it is left out here
   irq_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (zero_evt && st_q.regs.run && st_q.regs.irq_enable && !(reg_wr && reg_addr == ptt_pkg::OFS_CTRL))
         |=> tick_irq)
      else $error("Enabled zero gave no interrupt");
   irq_no_en_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!st_q.regs.irq_enable && !st_q.regs.tick_mask && !reg_wr) |=> !tick_irq)
      else $error("Interrupt without enable");
   ctrl_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == ptt_pkg::OFS_CTRL) |=> (st_q.regs.run == $past(reg_wdata[0])
         && st_q.regs.irq_enable == $past(reg_wdata[1])))
      else $error("Control write not taken");
   reload_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == ptt_pkg::OFS_RELOAD) |=> (st_q.regs.reload == $past(reg_wdata[23:0])))
      else $error("Reload write lost");
   ev_needs_run_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      zero_evt |-> $past(st_q.regs.run))
      else $error("Zero event while halted");
   pend_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (st_q.irq_pend && !irq_ack) |=> st_q.irq_pend)
      else $error("Pending request lost without accept");
   pend_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (irq_ack && !zero_evt) |=> !st_q.irq_pend)
      else $error("Accept did not drop request");
   stat_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      zero_evt |=> st_q.regs.tick_stat)
      else $error("Status not set on zero event");
   stat_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == ptt_pkg::OFS_IRQ_STAT && reg_wdata[0] && !zero_evt) |=> !st_q.regs.tick_stat)
      else $error("Status write one did not clear");
   irq_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (st_q.regs.tick_stat && st_q.regs.tick_mask && !reg_wr) |=> tick_irq)
      else $error("Unmasked status gave no interrupt");
   rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !reg_rd |=> (reg_rdata == 32'h00000000))
      else $error("Read data not zero when idle");
endmodule : ptt_top

/* File: test_periodic_tick_timer.sv */
// Self-checking testbench for the periodic tick timer
`timescale 1ns/1ps
module test_periodic_tick_timer;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h00000000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic irq_ack = 1'b0;
   logic [31:0] reg_rdata;
   logic tick_irq;
   logic [31:0] d;
   logic [31:0] e;
   int cyc = 0;
   int t1;
   int miscompares = 0;
   int compares = 0;

   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;

   ptt_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .irq_ack(irq_ack), .reg_rdata(reg_rdata), .tick_irq(tick_irq));

   task automatic finish_test();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(d, exp);
   endtask : rc

   task automatic ack();
      @(posedge ref_clk);
      irq_ack <= 1'b1;
      @(posedge ref_clk);
      irq_ack <= 1'b0;
   endtask : ack

   // Look just past the edge so the registered output has settled; a wait that runs out is a mismatch
   task automatic wait_lvl(input logic v);
      #1;
      for (int i = 0; i < 100 && tick_irq !== v; i++)
      begin
         @(posedge ref_clk);
         #1;
      end
      chk(tick_irq, v);
   endtask : wait_lvl

   task automatic t_reset();
      rc(ptt_pkg::OFS_CTRL, 32'h00000004);
      rc(ptt_pkg::OFS_RELOAD, 32'h00000000);
      rc(ptt_pkg::OFS_CURR, 32'h00000000);
      rc(ptt_pkg::OFS_CALIB, 32'h00000004);
      rc(ptt_pkg::OFS_IRQ_MASK, 32'h00000000);
      rc(8'h40, 32'h00000000);
   endtask : t_reset

   task automatic t_count();
      wr(ptt_pkg::OFS_RELOAD, 32'h00000003);
      rc(ptt_pkg::OFS_RELOAD, 32'h00000003);
      wr(ptt_pkg::OFS_CTRL, 32'h00000001);
      repeat (20) @(posedge ref_clk);
      wr(ptt_pkg::OFS_CTRL, 32'h00000000);
      #1;
      chk(tick_irq, 1'b0);
      wr(ptt_pkg::OFS_CURR, 32'h00FFFFFF);
      rc(ptt_pkg::OFS_CURR, 32'h00000000);
      rc(ptt_pkg::OFS_CTRL, 32'h00000004);
      wr(ptt_pkg::OFS_RELOAD, 32'h00000100);
      wr(ptt_pkg::OFS_CTRL, 32'h00000001);
      repeat (20) @(posedge ref_clk);
      rd(ptt_pkg::OFS_CURR);
      e = d;
      rd(ptt_pkg::OFS_CURR);
      chk(d, e - 32'h00000002);
      wr(ptt_pkg::OFS_CTRL, 32'h00000000);
      rd(ptt_pkg::OFS_CURR);
      e = d;
      repeat (5) @(posedge ref_clk);
      rc(ptt_pkg::OFS_CURR, e);
      wr(ptt_pkg::OFS_CURR, 32'h00000000);
      wr(ptt_pkg::OFS_RELOAD, 32'h00000003);
      wr(ptt_pkg::OFS_CTRL, 32'h00000001);
      repeat (20) @(posedge ref_clk);
      wr(ptt_pkg::OFS_CTRL, 32'h00000000);
      rc(ptt_pkg::OFS_CTRL, 32'h00010004);
      rc(ptt_pkg::OFS_CTRL, 32'h00000004);
   endtask : t_count

   // Spacing of two request rises must equal reload plus one
   task automatic t_irq();
      wr(ptt_pkg::OFS_RELOAD, 32'h00000007);
      wr(ptt_pkg::OFS_CTRL, 32'h00000003);
      wait_lvl(1'b1);
      repeat (12) @(posedge ref_clk);
      #1;
      chk(tick_irq, 1'b1);
      ack();
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      t1 = cyc;
      ack();
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      chk(32'(cyc - t1), 32'h00000008);
      rc(ptt_pkg::OFS_CTRL, 32'h00010007);
      wr(ptt_pkg::OFS_CTRL, 32'h00000001);
      ack();
      repeat (30) @(posedge ref_clk);
      #1;
      chk(tick_irq, 1'b0);
   endtask : t_irq

   task automatic t_stat();
      wr(ptt_pkg::OFS_CTRL, 32'h00000000);
      wr(ptt_pkg::OFS_IRQ_STAT, 32'h00000001);
      rc(ptt_pkg::OFS_IRQ_STAT, 32'h00000000);
      wr(ptt_pkg::OFS_IRQ_MASK, 32'h00000001);
      rc(ptt_pkg::OFS_IRQ_MASK, 32'h00000001);
      wr(ptt_pkg::OFS_CTRL, 32'h00000001);
      wait_lvl(1'b1);
      chk(tick_irq, 1'b1);
      wr(ptt_pkg::OFS_CTRL, 32'h00000000);
      wr(ptt_pkg::OFS_IRQ_STAT, 32'h00000001);
      repeat (3) @(posedge ref_clk);
      #1;
      chk(tick_irq, 1'b0);
      wr(ptt_pkg::OFS_IRQ_MASK, 32'h00000000);
      wr(ptt_pkg::OFS_CTRL, 32'h00000001);
      repeat (20) @(posedge ref_clk);
      rc(ptt_pkg::OFS_IRQ_STAT, 32'h00000001);
      chk(tick_irq, 1'b0);
      wr(ptt_pkg::OFS_CTRL, 32'h00000000);
   endtask : t_stat

   // Software copies the default period into the reload register
   task automatic t_calib();
      rd(ptt_pkg::OFS_CALIB);
      wr(ptt_pkg::OFS_RELOAD, {8'h00, d[23:0]});
      rc(ptt_pkg::OFS_RELOAD, {8'h00, ptt_pkg::RST_DEFAULT_PERIOD});
      wr(ptt_pkg::OFS_CALIB, 32'hC0123456);
      rc(ptt_pkg::OFS_CALIB, 32'hC0123456);
      wr(ptt_pkg::OFS_CALIB, 32'h00000000);
      rc(ptt_pkg::OFS_CALIB, 32'h00000000);
   endtask : t_calib

   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_reset();
      t_count();
      t_irq();
      t_stat();
      t_calib();
      finish_test();
   end

   // The tests need well under a thousand cycles; allow forty thousand
   initial
   begin
      #2000000;
      miscompares++;
      finish_test();
   end
endmodule : test_periodic_tick_timer
